//--- rtl/smc_pkg.sv
// Package with register map, field layout and types of the switch matrix
package smc_pkg;

    // Bus widths
    localparam int SMC_ADDR_W = 16;
    localparam int SMC_DATA_W = 32;
    localparam int SMC_STRB_W = SMC_DATA_W / 8;
    localparam int SMC_WORD_LSB = 2;

    typedef logic [SMC_ADDR_W-1:0] smc_addr_t;
    typedef logic [SMC_DATA_W-1:0] smc_data_t;
    typedef logic [SMC_STRB_W-1:0] smc_strb_t;

    // Register byte offsets
    localparam smc_addr_t SMC_OFF_MATRIX_CFG = 16'h200C;
    localparam smc_addr_t SMC_OFF_DRIVE_FULL = 16'h2150;
    localparam smc_addr_t SMC_OFF_NEG_FULL = 16'h2154;
    localparam smc_addr_t SMC_OFF_POS_FULL = 16'h2158;
    localparam smc_addr_t SMC_OFF_AMP_FULL = 16'h215C;
    localparam smc_addr_t SMC_OFF_DRIVE_STA = 16'h21B0;
    localparam smc_addr_t SMC_OFF_POS_STA = 16'h21B4;
    localparam smc_addr_t SMC_OFF_NEG_STA = 16'h21B8;
    localparam smc_addr_t SMC_OFF_AMP_STA = 16'h21BC;

    // Reset values
    localparam smc_data_t SMC_RST_MATRIX_CFG = 32'h0000FFFF;
    localparam smc_data_t SMC_RST_ZERO = 32'h00000000;

    // Writable bits of each register, the rest read as zero
    localparam smc_data_t SMC_MASK_MATRIX_CFG = 32'h0001FFFF;
    localparam smc_data_t SMC_MASK_SIDE_FULL = 32'h0000FFFF;
    localparam smc_data_t SMC_MASK_AMP_FULL = 32'h00000FFF;

    // Group fields of the matrix configuration register
    localparam int SMC_GRP_W = 4;
    localparam int SMC_GRP_SPAN = 12;
    localparam int SMC_GRP_DRIVE_LSB = 0;
    localparam int SMC_GRP_POS_LSB = 4;
    localparam int SMC_GRP_NEG_LSB = 8;
    localparam int SMC_GRP_AMP_LSB = 12;
    localparam int SMC_SRC_SEL_BIT = 16;

    // Named switch bits inside the full configuration registers
    localparam int SMC_DRIVE_CAL_BIT = 11;
    localparam int SMC_POS_CAL_BIT = 11;
    localparam int SMC_NEG_CAL_BIT = 11;
    localparam int SMC_AMP_CAL_BIT = 11;
    localparam int SMC_SENSE_BIT = 9;
    localparam int SMC_ELEC_LSB = 12;
    localparam int SMC_ELEC_W = 3;
    localparam int SMC_TIE_BIT = 12;
    localparam int SMC_TIE2_BIT = 13;

    // AXI response codes
    localparam logic [1:0] SMC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SMC_RESP_SLVERR = 2'h2;

    // Applied state of all four switch groups
    typedef struct packed {
        smc_data_t amp;
        smc_data_t negative;
        smc_data_t positive;
        smc_data_t drive;
    } smc_sw_state_t;

    // Decoded analog routing controls
    typedef struct packed {
        logic cal_a_drive;
        logic cal_a_positive;
        logic cal_b_negative;
        logic cal_b_amp;
        logic sense_amp;
        logic positive_low_tie;
        logic positive_low_tie_second;
        logic negative_low_tie;
        logic negative_low_tie_second;
        logic [SMC_ELEC_W-1:0] electrode_route;
    } smc_route_t;

    // Byte-lane merge of a write into a register, limited to its mask
    function automatic smc_data_t smc_merge(input smc_data_t old_v,
                                            input smc_data_t new_v,
                                            input smc_strb_t strb,
                                            input smc_data_t mask);
        smc_data_t res;
        res = old_v;
        for (int b = 0; b < SMC_STRB_W; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction : smc_merge

endpackage : smc_pkg

//--- rtl/smc_group_decode.sv
// Decoder from one group code to the closed switches of that group
`timescale 1ns/1ps
`default_nettype none

module smc_group_decode #(
    parameter int CODE_W = 4,
    parameter int OUT_W = 32,
    parameter int SPAN = 12
) (
    // Group code
    input wire logic [CODE_W-1:0] code_i,
    // One switch closed, or none for codes beyond the span
    output logic [OUT_W-1:0] closed_o
);

    // One-hot select; out-of-span codes leave the group open
    always_comb begin
        closed_o = '0;
        for (int i = 0; i < SPAN; i++) begin
            closed_o[i] = (code_i == CODE_W'(i));
        end
    end

endmodule : smc_group_decode

`default_nettype wire

//--- rtl/smc_switch_matrix.sv
// Switch matrix register bank with AXI4-Lite slave and applied states
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module smc_switch_matrix (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire smc_pkg::smc_addr_t s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire smc_pkg::smc_data_t s_axi_wdata,
    input wire smc_pkg::smc_strb_t s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire smc_pkg::smc_addr_t s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output smc_pkg::smc_data_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Analog switch controls
    output smc_pkg::smc_sw_state_t sw_state_o,
    output smc_pkg::smc_route_t route_o,
    output logic src_full_o
);
    import smc_pkg::*;

    // Write channel holding state
    logic aw_hold_r;
    smc_addr_t aw_addr_r;
    logic w_hold_r;
    smc_data_t w_data_r;
    smc_strb_t w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    // Read channel state
    logic rvalid_r;
    smc_data_t rdata_r;
    logic [1:0] rresp_r;

    // Software registers
    smc_data_t matrix_cfg_r;
    smc_data_t drive_full_r;
    smc_data_t neg_full_r;
    smc_data_t pos_full_r;
    smc_data_t amp_full_r;

    // Full config copy taken when source select is set
    smc_sw_state_t full_snap_r;

    // Applied switch states, also the status registers
    smc_sw_state_t applied_r;
    smc_sw_state_t applied_nxt;
    smc_sw_state_t group_closed;

    // Write strobe and decode
    logic wr_go;
    smc_addr_t wr_word;
    smc_addr_t rd_word;
    logic wr_hit;
    logic src_sel;

    // Word-aligned addresses ignore the byte lane bits
    assign wr_word = {aw_addr_r[SMC_ADDR_W-1:SMC_WORD_LSB],
                      SMC_WORD_LSB'(0)};
    assign rd_word = {s_axi_araddr[SMC_ADDR_W-1:SMC_WORD_LSB],
                      SMC_WORD_LSB'(0)};

    // A write fires once address and data are both held
    // Nothing new is taken while a response waits for bready
    assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
    assign src_sel = matrix_cfg_r[SMC_SRC_SEL_BIT];

    // Handshake outputs
    // Ready stays low while a channel is held or a reply waits
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Hit check over the map for writes
    // Status words are hits too, so their ignored writes answer OKAY
    always_comb begin
        case (wr_word)
            SMC_OFF_MATRIX_CFG,
            SMC_OFF_DRIVE_FULL,
            SMC_OFF_NEG_FULL,
            SMC_OFF_POS_FULL,
            SMC_OFF_AMP_FULL,
            SMC_OFF_DRIVE_STA,
            SMC_OFF_POS_STA,
            SMC_OFF_NEG_STA,
            SMC_OFF_AMP_STA: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write address capture
    // Address and data may arrive in either order
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_hold_r <= 1'b0;
        end
    end

    // Write data capture
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            w_hold_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_hold_r <= 1'b0;
        end
    end

    // Write response, error for unmapped words
    // The response stands until the master raises bready
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bvalid_r <= 1'b0;
            bresp_r <= SMC_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Matrix configuration register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            matrix_cfg_r <= SMC_RST_MATRIX_CFG;
        end else if (wr_go && wr_word == SMC_OFF_MATRIX_CFG) begin
            matrix_cfg_r <= smc_merge(matrix_cfg_r, w_data_r, w_strb_r,
                                      SMC_MASK_MATRIX_CFG);
        end
    end

    // Full configuration registers, stored but not yet applied
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            drive_full_r <= SMC_RST_ZERO;
            neg_full_r <= SMC_RST_ZERO;
            pos_full_r <= SMC_RST_ZERO;
            amp_full_r <= SMC_RST_ZERO;
        end else if (wr_go) begin
            case (wr_word)
                SMC_OFF_DRIVE_FULL: begin
                    drive_full_r <= smc_merge(drive_full_r, w_data_r,
                                              w_strb_r, SMC_MASK_SIDE_FULL);
                end
                SMC_OFF_NEG_FULL: begin
                    neg_full_r <= smc_merge(neg_full_r, w_data_r,
                                            w_strb_r, SMC_MASK_SIDE_FULL);
                end
                SMC_OFF_POS_FULL: begin
                    pos_full_r <= smc_merge(pos_full_r, w_data_r,
                                            w_strb_r, SMC_MASK_SIDE_FULL);
                end
                SMC_OFF_AMP_FULL: begin
                    // Upper bits stay zero
                    amp_full_r <= smc_merge(amp_full_r, w_data_r,
                                            w_strb_r, SMC_MASK_AMP_FULL);
                end
                default: begin
                    // Other words leave these alone
                end
            endcase
        end
    end

    // Snapshot of full config at each write that sets source select
    // Later full writes are only stored, so software can stage
    // several registers and move every switch on one edge
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            full_snap_r <= '0;
        end else if (wr_go && wr_word == SMC_OFF_MATRIX_CFG &&
                     w_strb_r[SMC_SRC_SEL_BIT/8] &&
                     w_data_r[SMC_SRC_SEL_BIT]) begin
            full_snap_r.drive <= drive_full_r;
            full_snap_r.negative <= neg_full_r;
            full_snap_r.positive <= pos_full_r;
            full_snap_r.amp <= amp_full_r;
        end
    end

    // Group decoders, one per switch group
    // Codes beyond the span leave that group fully open
    smc_group_decode #(
        .CODE_W(SMC_GRP_W),
        .OUT_W(SMC_DATA_W),
        .SPAN(SMC_GRP_SPAN)
    ) u_dec_drive (
        .code_i(matrix_cfg_r[SMC_GRP_DRIVE_LSB +: SMC_GRP_W]),
        .closed_o(group_closed.drive)
    );

    smc_group_decode #(
        .CODE_W(SMC_GRP_W),
        .OUT_W(SMC_DATA_W),
        .SPAN(SMC_GRP_SPAN)
    ) u_dec_pos (
        .code_i(matrix_cfg_r[SMC_GRP_POS_LSB +: SMC_GRP_W]),
        .closed_o(group_closed.positive)
    );

    smc_group_decode #(
        .CODE_W(SMC_GRP_W),
        .OUT_W(SMC_DATA_W),
        .SPAN(SMC_GRP_SPAN)
    ) u_dec_neg (
        .code_i(matrix_cfg_r[SMC_GRP_NEG_LSB +: SMC_GRP_W]),
        .closed_o(group_closed.negative)
    );

    smc_group_decode #(
        .CODE_W(SMC_GRP_W),
        .OUT_W(SMC_DATA_W),
        .SPAN(SMC_GRP_SPAN)
    ) u_dec_amp (
        .code_i(matrix_cfg_r[SMC_GRP_AMP_LSB +: SMC_GRP_W]),
        .closed_o(group_closed.amp)
    );

    // Choose the control path for the switches
    // Group control after reset, since the select bit resets clear
    always_comb begin
        if (src_sel) begin
            applied_nxt = full_snap_r;
        end else begin
            applied_nxt = group_closed;
        end
    end

    // Applied switch state, open from reset
    // Registered so every switch moves on a single clean edge
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            applied_r <= '0;
        end else begin
            applied_r <= applied_nxt;
        end
    end

    // Read decode of registers and status
    // Unmapped words read zero with a slave error
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= SMC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= SMC_RESP_OKAY;
            case (rd_word)
                SMC_OFF_MATRIX_CFG: rdata_r <= matrix_cfg_r;
                SMC_OFF_DRIVE_FULL: rdata_r <= drive_full_r;
                SMC_OFF_NEG_FULL: rdata_r <= neg_full_r;
                SMC_OFF_POS_FULL: rdata_r <= pos_full_r;
                SMC_OFF_AMP_FULL: rdata_r <= amp_full_r;
                // Status words mirror the applied switches
                SMC_OFF_DRIVE_STA: rdata_r <= applied_r.drive;
                SMC_OFF_POS_STA: rdata_r <= applied_r.positive;
                SMC_OFF_NEG_STA: rdata_r <= applied_r.negative;
                SMC_OFF_AMP_STA: rdata_r <= applied_r.amp;
                default: begin
                    rdata_r <= '0;
                    rresp_r <= SMC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Switch state outputs
    assign sw_state_o = applied_r;
    assign src_full_o = src_sel;

    // Named analog links from the applied bits
    // Links follow whichever control path is active
    always_comb begin
        route_o.cal_a_drive = applied_r.drive[SMC_DRIVE_CAL_BIT];
        route_o.cal_a_positive = applied_r.positive[SMC_POS_CAL_BIT];
        route_o.cal_b_negative = applied_r.negative[SMC_NEG_CAL_BIT];
        route_o.cal_b_amp = applied_r.amp[SMC_AMP_CAL_BIT];
        route_o.sense_amp = applied_r.amp[SMC_SENSE_BIT];
        // Low ties for hibernate, closed by software
        route_o.positive_low_tie = applied_r.positive[SMC_TIE_BIT];
        route_o.positive_low_tie_second = applied_r.positive[SMC_TIE2_BIT];
        route_o.negative_low_tie = applied_r.negative[SMC_TIE_BIT];
        route_o.negative_low_tie_second = applied_r.negative[SMC_TIE2_BIT];
        // Electrode switches only, never a converter input
        route_o.electrode_route =
            applied_r.drive[SMC_ELEC_LSB +: SMC_ELEC_W];
    end

endmodule : smc_switch_matrix

`default_nettype wire

//--- bench/smc_switch_matrix_asserts.sv
// Port checker of the switch matrix register bank
`timescale 1ns/1ps
`default_nettype none
module smc_switch_matrix_asserts (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Switch outputs
    input wire smc_pkg::smc_sw_state_t sw_state_o,
    input wire smc_pkg::smc_route_t route_o,
    input wire logic src_full_o
);
    import smc_pkg::*;
    // One clock domain for all checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    AST_RST_OPEN: assert property ($rose(rst_b_i) |->
        sw_state_o == '0 && route_o == '0 && !src_full_o)
        else $error("switches not open after reset");
    AST_CAL_A: assert property (
        route_o.cal_a_drive == sw_state_o.drive[SMC_DRIVE_CAL_BIT] &&
        route_o.cal_a_positive == sw_state_o.positive[SMC_POS_CAL_BIT])
        else $error("pin A calibration route wrong");
    AST_CAL_B: assert property (
        route_o.cal_b_negative == sw_state_o.negative[SMC_NEG_CAL_BIT] &&
        route_o.cal_b_amp == sw_state_o.amp[SMC_AMP_CAL_BIT] &&
        route_o.sense_amp == sw_state_o.amp[SMC_SENSE_BIT])
        else $error("pin B or sense route wrong");
    AST_ELEC: assert property (
        route_o.electrode_route ==
        sw_state_o.drive[SMC_ELEC_LSB +: SMC_ELEC_W])
        else $error("electrode route wrong");
    AST_TIES: assert property (
        {route_o.positive_low_tie, route_o.positive_low_tie_second} ==
        {sw_state_o.positive[12], sw_state_o.positive[13]} &&
        {route_o.negative_low_tie, route_o.negative_low_tie_second} ==
        {sw_state_o.negative[12], sw_state_o.negative[13]})
        else $error("low tie route wrong");
    AST_SW_CAUSE: assert property (!$stable(sw_state_o) |->
        $past(s_axi_bvalid))
        else $error("switches moved without a write");
    AST_SRC_CAUSE: assert property (!$stable(src_full_o) |->
        s_axi_bvalid || $past(s_axi_bvalid))
        else $error("source select moved without a write");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready)
        else $error("write response not retired");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid)
        else $error("read data not retired");
endmodule : smc_switch_matrix_asserts
bind smc_switch_matrix smc_switch_matrix_asserts smc_switch_matrix_asserts_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sw_state_o(sw_state_o), .route_o(route_o), .src_full_o(src_full_o)
);
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench of the switch matrix register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import smc_pkg::*;
    // Bench driven inputs
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    smc_addr_t s_axi_awaddr = '0, s_axi_araddr = '0;
    smc_data_t s_axi_wdata = '0;
    smc_strb_t s_axi_wstrb = '0;
    // Design outputs
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, src_full_o;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    smc_data_t s_axi_rdata;
    smc_sw_state_t sw_state_o, e;
    smc_route_t route_o;
    // Scoreboard and full register table
    int error_cnt = 0;
    int cmp_count = 0;
    smc_addr_t fadr[4] = '{SMC_OFF_DRIVE_FULL, SMC_OFF_NEG_FULL,
        SMC_OFF_POS_FULL, SMC_OFF_AMP_FULL};
    smc_data_t fwr[4] = '{32'h5800, 32'h2800, 32'h1800, 32'hFFFFFFFF};
    smc_data_t frd[4] = '{32'h5800, 32'h2800, 32'h1800, 32'h00000FFF};
    // Free running clock
    always #5 clk_i = ~clk_i;
    smc_switch_matrix smc_switch_matrix_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .sw_state_o(sw_state_o),
        .route_o(route_o), .src_full_o(src_full_o));
    // Verdict and end of run
    task automatic complete_run();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    // Wait limit on every bus loop
    task automatic hang(input int n);
        if (n > 40) begin
            $display("ERROR %0t wait limit", $time);
            error_cnt++;
            complete_run();
        end
    endtask : hang
    // Compare one data word
    task automatic chk_data(input smc_data_t got, input smc_data_t exp);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR %0t data %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk_data
    // Compare one response code
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR %0t resp %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk_resp
    // One write, address and data offered together
    task automatic wr(input smc_addr_t a, input smc_data_t d,
                      input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        int n;
        n = 0;
        tb = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!tb) begin
            @(negedge clk_i);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            n++;
            hang(n);
        end
        chk_resp(r, er);
    endtask : wr
    // One read with expected word and response
    task automatic rd(input smc_addr_t a, input smc_data_t ed,
                      input logic [1:0] er);
        logic ta, tr;
        logic [1:0] r;
        smc_data_t d;
        int n;
        n = 0;
        tr = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!tr) begin
            @(negedge clk_i);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_i);
            if (ta) s_axi_arvalid <= 1'b0;
            n++;
            hang(n);
        end
        chk_data(d, ed);
        chk_resp(r, er);
    endtask : rd
    // Applied switches on the port and in the status words
    task automatic chk_sw(input smc_sw_state_t x);
        @(negedge clk_i);
        chk_data(sw_state_o.drive, x.drive);
        chk_data(sw_state_o.positive, x.positive);
        chk_data(sw_state_o.negative, x.negative);
        chk_data(sw_state_o.amp, x.amp);
        @(posedge clk_i);
        rd(SMC_OFF_DRIVE_STA, x.drive, SMC_RESP_OKAY);
        rd(SMC_OFF_POS_STA, x.positive, SMC_RESP_OKAY);
        rd(SMC_OFF_NEG_STA, x.negative, SMC_RESP_OKAY);
        rd(SMC_OFF_AMP_STA, x.amp, SMC_RESP_OKAY);
    endtask : chk_sw
    // Routing controls derived from the applied switches
    task automatic chk_route(input smc_sw_state_t x);
        smc_route_t r;
        r = {x.drive[11], x.positive[11], x.negative[11], x.amp[11],
             x.amp[9], x.positive[12], x.positive[13], x.negative[12],
             x.negative[13], x.drive[14:12]};
        chk_data(32'(route_o), 32'(r));
    endtask : chk_route
    // Group code to one closed switch
    function automatic smc_data_t dec(input logic [3:0] c);
        return (c < 4'hC) ? (32'h1 << c) : 32'h0;
    endfunction : dec
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        s_axi_bready <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge clk_i);
        chk_sw('0);
        rd(SMC_OFF_MATRIX_CFG, SMC_RST_MATRIX_CFG, SMC_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            rd(fadr[i], SMC_RST_ZERO, SMC_RESP_OKAY);
        end
        // Every code in every group, groups offset
        for (int c = 0; c < 16; c++) begin
            wr(SMC_OFF_MATRIX_CFG, {16'h0, 4'(c + 3), 4'(c + 2),
                4'(c + 1), 4'(c)}, SMC_RESP_OKAY);
            e = {dec(4'(c + 3)), dec(4'(c + 2)), dec(4'(c + 1)), dec(4'(c))};
            chk_sw(e);
        end
        // Full words stored but not yet applied
        for (int i = 0; i < 4; i++) begin
            wr(fadr[i], fwr[i], SMC_RESP_OKAY);
            rd(fadr[i], frd[i], SMC_RESP_OKAY);
        end
        chk_sw(e);
        wr(SMC_OFF_MATRIX_CFG, 32'h0001FFFF, SMC_RESP_OKAY);
        e = {frd[3], frd[0 + 1], frd[2], frd[0]};
        chk_sw(e);
        chk_route(e);
        chk_data({31'h0, src_full_o}, 32'h1);
        // Later full write waits for a fresh select
        wr(SMC_OFF_AMP_FULL, 32'h00000200, SMC_RESP_OKAY);
        chk_sw(e);
        wr(SMC_OFF_MATRIX_CFG, 32'h0001FFFF, SMC_RESP_OKAY);
        e.amp = 32'h00000200;
        chk_sw(e);
        chk_route(e);
        // Second reset in mid-run
        rst_b_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        chk_sw('0);
        chk_data({31'h0, src_full_o}, 32'h0);
        rd(SMC_OFF_MATRIX_CFG, SMC_RST_MATRIX_CFG, SMC_RESP_OKAY);
        rd(SMC_OFF_AMP_FULL, SMC_RST_ZERO, SMC_RESP_OKAY);
        // Unmapped word and read-only status word
        wr(16'h2000, 32'hFFFFFFFF, SMC_RESP_SLVERR);
        rd(16'h2000, 32'h0, SMC_RESP_SLVERR);
        wr(SMC_OFF_AMP_STA, 32'hFFFFFFFF, SMC_RESP_OKAY);
        rd(SMC_OFF_AMP_STA, SMC_RST_ZERO, SMC_RESP_OKAY);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
